// ==== cpu_glue.sv ====
// Processor glue: register bank, I/O ports, watchdog, peripheral decode
`timescale 1ns/1ps
module cpu_glue #(
    parameter int WD_TIMEOUT = glue_pkg::WD_TIMEOUT_CYCLES,
    parameter int WD_PULSE = glue_pkg::WD_PULSE_CYCLES,
    parameter logic [7:0] KEY_A = glue_pkg::WD_KEY_A_VALUE,
    parameter logic [7:0] KEY_B = glue_pkg::WD_KEY_B_VALUE,
    parameter logic [11:0] WINDOW = glue_pkg::REG_WINDOW,
    parameter logic [glue_pkg::PERIPH_COUNT*glue_pkg::ADDR_WIDTH-1:0] RANGE_LO = {
        16'he000, 16'hc000, 16'ha000, 16'h8000, 16'h6000, 16'h4000, 16'h2000, 16'h0000},
    parameter logic [glue_pkg::PERIPH_COUNT*glue_pkg::ADDR_WIDTH-1:0] RANGE_HI = {
        16'hffef, 16'hdfff, 16'hbfff, 16'h9fff, 16'h7fff, 16'h5fff, 16'h3fff, 16'h1fff}
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic chip_select,
    input wire logic [glue_pkg::ADDR_WIDTH-1:0] addr,
    input wire logic read_not_write,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic rdata_oe,
    output logic [7:0] out_pins,
    input wire logic [7:0] in_pins,
    input wire logic wd_disable,
    output logic wd_reset,
    output logic [glue_pkg::PERIPH_COUNT-1:0] periph_sel,
    output logic [glue_pkg::PERIPH_COUNT-1:0] periph_rd,
    output logic [glue_pkg::PERIPH_COUNT-1:0] periph_wr,
    input wire logic [glue_pkg::SER_COUNT-1:0] ser_in,
    input wire logic [glue_pkg::SER_COUNT*glue_pkg::SER_SEL_WIDTH-1:0] ser_sel,
    output logic [glue_pkg::SER_COUNT-1:0] ser_out
);
    import glue_pkg::*;

    // Watchdog modes: counting, driving the reset pulse, or held off by the jumper.
    // Three states in two bits leave one code unused; it falls back to counting.
    typedef enum logic [1:0] {WD_RUN, WD_FIRE, WD_OFF} wd_state_e;

    // Address range test, shared by every decoder slot
    function automatic logic in_range(input logic [ADDR_WIDTH-1:0] a,
                                      input logic [ADDR_WIDTH-1:0] lo,
                                      input logic [ADDR_WIDTH-1:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    logic reg_hit;
    logic reg_wr;
    logic reg_rd;
    logic [3:0] reg_ofs;
    logic [7:0] next_rdata;
    logic next_rdata_oe;
    logic [7:0] next_out_pins;
    // Refresh progress: set by a good first key, used up by any second-key write
    logic armed;
    logic next_armed;
    logic restart;
    // Wide enough for a timeout of seconds at the system clock rate
    logic [31:0] wd_count;
    logic [31:0] next_wd_count;
    wd_state_e wd_state;
    wd_state_e next_wd_state;
    logic next_wd_reset;
    logic [PERIPH_COUNT-1:0] next_periph_sel;
    logic [PERIPH_COUNT-1:0] next_periph_rd;
    logic [PERIPH_COUNT-1:0] next_periph_wr;

    // Register window: chip select plus upper address, low four lines pick the register
    assign reg_hit = chip_select && (addr[ADDR_WIDTH-1:4] == WINDOW);
    assign reg_ofs = addr[3:0];
    assign reg_wr = reg_hit && !read_not_write;
    assign reg_rd = reg_hit && read_not_write;

    // Bus read mux and output latch
    // The drive enable follows each read request for exactly one cycle
    always_comb begin
        next_rdata = READ_IDLE;
        next_rdata_oe = reg_rd;
        next_out_pins = out_pins;
        if (reg_rd) begin
            unique case (reg_ofs)
                OFS_OUT_PORT: next_rdata = out_pins;
                OFS_IN_PORT: next_rdata = in_pins;
                // Status lets software see the jumper and whether a refresh is half done
                OFS_WD_STATUS: begin
                    next_rdata[ST_ARMED_BIT] = armed;
                    next_rdata[ST_DISABLE_BIT] = wd_disable;
                    next_rdata[ST_RESET_BIT] = wd_reset;
                end
                default: next_rdata = READ_IDLE; // Key registers are write only
            endcase
        end
        if (reg_wr && reg_ofs == OFS_OUT_PORT) begin
            next_out_pins = wdata;
        end
    end

    // Read data registered, so it appears the cycle after the request
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= READ_IDLE;
            rdata_oe <= 1'b0;
            out_pins <= OUT_PORT_RESET;
        end else begin
            rdata <= next_rdata;
            rdata_oe <= next_rdata_oe;
            out_pins <= next_out_pins;
        end
    end

    // Refresh sequence: key A arms, key B while armed restarts; any bad write disarms.
    // Ordering the keys stops a single stray write from feeding the dog.
    always_comb begin
        next_armed = armed;
        restart = 1'b0;
        if (reg_wr && reg_ofs == OFS_WD_KEY_A) begin
            next_armed = (wdata == KEY_A);
        end else if (reg_wr && reg_ofs == OFS_WD_KEY_B) begin
            restart = armed && (wdata == KEY_B);
            next_armed = 1'b0;
        end
    end

    // Watchdog counter and reset pulse
    always_comb begin
        next_wd_state = wd_state;
        next_wd_count = wd_count + 32'h1;
        next_wd_reset = 1'b0;
        unique case (wd_state)
            WD_RUN: begin
                if (restart) begin
                    next_wd_count = '0;
                end else if (wd_count >= 32'(WD_TIMEOUT - 1)) begin
                    next_wd_state = WD_FIRE;
                    next_wd_count = '0;
                    next_wd_reset = 1'b1;
                end
            end
            WD_FIRE: begin
                next_wd_reset = 1'b1;
                if (wd_count >= 32'(WD_PULSE - 1)) begin
                    next_wd_state = WD_RUN;
                    next_wd_count = '0;
                    next_wd_reset = 1'b0;
                end
            end
            // Jumper just removed: start a full timeout from zero
            WD_OFF: begin
                next_wd_count = '0;
                next_wd_state = WD_RUN;
            end
            default: begin
                next_wd_count = '0;
                next_wd_state = WD_RUN;
            end
        endcase
        // Jumper wins over everything, even a pulse in progress, which is cut short;
        // a board strapped for debug must never see a reset from this block
        if (wd_disable) begin
            next_wd_state = WD_OFF;
            next_wd_count = '0;
            next_wd_reset = 1'b0;
        end
    end

    // Watchdog state registers; reset leaves the dog counting and unarmed
    // so a processor that never starts its software still gets reset
    always_ff @(posedge clk) begin
        if (reset) begin
            armed <= 1'b0;
            wd_state <= WD_RUN;
            wd_count <= '0;
            wd_reset <= 1'b0;
        end else begin
            armed <= next_armed;
            wd_state <= next_wd_state;
            wd_count <= next_wd_count;
            wd_reset <= next_wd_reset;
        end
    end

    // Peripheral decode; a register window hit masks every range, so the two never both answer
    always_comb begin
        for (int i = 0; i < PERIPH_COUNT; i++) begin
            next_periph_sel[i] = chip_select && !reg_hit && in_range(addr,
                RANGE_LO[i*ADDR_WIDTH +: ADDR_WIDTH], RANGE_HI[i*ADDR_WIDTH +: ADDR_WIDTH]);
            next_periph_rd[i] = next_periph_sel[i] && read_not_write;
            next_periph_wr[i] = next_periph_sel[i] && !read_not_write;
        end
    end

    // Decode registered so the control pins are glitch free;
    // the cost is one cycle of latency after the bus cycle starts
    always_ff @(posedge clk) begin
        if (reset) begin
            periph_sel <= '0;
            periph_rd <= '0;
            periph_wr <= '0;
        end else begin
            periph_sel <= next_periph_sel;
            periph_rd <= next_periph_rd;
            periph_wr <= next_periph_wr;
        end
    end

    // Serial crossbar, steered by the switch inputs
    serial_router u_router (
        .clk(clk),
        .reset(reset),
        .ser_in(ser_in),
        .ser_sel(ser_sel),
        .ser_out(ser_out)
    );
endmodule : cpu_glue

// ==== glue_pkg.sv ====
// Shared constants for the processor glue logic block
package glue_pkg;
    // Register offsets on the four decoded address lines
    localparam logic [3:0] OFS_OUT_PORT = 4'h0;
    localparam logic [3:0] OFS_IN_PORT = 4'h1;
    localparam logic [3:0] OFS_WD_KEY_A = 4'h2;
    localparam logic [3:0] OFS_WD_KEY_B = 4'h3;
    localparam logic [3:0] OFS_WD_STATUS = 4'h4;
    // Status register bit positions
    localparam int ST_ARMED_BIT = 0;
    localparam int ST_DISABLE_BIT = 1;
    localparam int ST_RESET_BIT = 2;
    // Reset values
    localparam logic [7:0] OUT_PORT_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;
    // Refresh key defaults
    localparam logic [7:0] WD_KEY_A_VALUE = 8'h55;
    localparam logic [7:0] WD_KEY_B_VALUE = 8'haa;
    // Timing: clock rate and watchdog times
    localparam int CLK_HZ = 20_000_000;
    localparam int WD_TIMEOUT_US = 100_000;
    localparam int WD_TIMEOUT_CYCLES = (WD_TIMEOUT_US / 1000) * (CLK_HZ / 1000);
    localparam int WD_PULSE_US = 10;
    localparam int WD_PULSE_CYCLES = WD_PULSE_US * (CLK_HZ / 1_000_000);
    // Peripheral decoder
    localparam int PERIPH_COUNT = 8;
    localparam int ADDR_WIDTH = 16;
    localparam logic [11:0] REG_WINDOW = 12'hfff;
    // Serial router
    localparam int SER_COUNT = 4;
    localparam int SER_SEL_WIDTH = 2;
endpackage : glue_pkg

// ==== serial_router.sv ====
// Switch steered crossbar for the four serial lines
`timescale 1ns/1ps
module serial_router (
    input wire logic clk,
    input wire logic reset,
    input wire logic [glue_pkg::SER_COUNT-1:0] ser_in,
    input wire logic [glue_pkg::SER_COUNT*glue_pkg::SER_SEL_WIDTH-1:0] ser_sel,
    output logic [glue_pkg::SER_COUNT-1:0] ser_out
);
    import glue_pkg::*;

    logic [SER_COUNT-1:0] next_ser_out;

    // Each output picks its own input from its own select pair
    always_comb begin
        for (int i = 0; i < SER_COUNT; i++) begin
            next_ser_out[i] = ser_in[ser_sel[i*SER_SEL_WIDTH +: SER_SEL_WIDTH]];
        end
    end

    // Registered so the pins change on the clock only; costs one cycle of delay
    always_ff @(posedge clk) begin
        if (reset) begin
            ser_out <= '0;
        end else begin
            ser_out <= next_ser_out;
        end
    end
endmodule : serial_router

// ==== cpu_glue_asserts.sv ====
// Port checker for the processor glue block
`timescale 1ns/1ps
module cpu_glue_asserts import glue_pkg::*; #(
    parameter logic [11:0] WINDOW = 12'hfff
) (
    input wire logic clk, reset, chip_select, read_not_write, wd_disable, wd_reset, rdata_oe,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata, rdata, out_pins, in_pins, periph_sel, periph_rd, periph_wr,
    input wire logic [3:0] ser_in, ser_out,
    input wire logic [7:0] ser_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Register window hit, shared by the bus checks
    logic hit;
    logic wr_out;
    assign hit = chip_select && addr[15:4] == WINDOW;
    assign wr_out = hit && !read_not_write && addr[3:0] == OFS_OUT_PORT;
    a_out_latch: assert property (wr_out |=> out_pins == $past(wdata))
        else $error("output latch missed a write");
    a_out_hold: assert property (!wr_out |=> $stable(out_pins))
        else $error("output latch changed without a write");
    a_out_read: assert property (hit && read_not_write && addr[3:0] == OFS_OUT_PORT
        |=> rdata_oe && rdata == $past(out_pins)) else $error("output readback wrong");
    a_in_read: assert property (hit && read_not_write && addr[3:0] == OFS_IN_PORT
        |=> rdata_oe && rdata == $past(in_pins)) else $error("input port read wrong");
    a_unmapped_read: assert property (hit && read_not_write && addr[3:0] > OFS_WD_STATUS
        |=> rdata_oe && rdata == READ_IDLE) else $error("unmapped read not idle");
    a_oe_quiet: assert property (!(hit && read_not_write) |=> !rdata_oe)
        else $error("data bus driven without a read");
    a_wd_blocked: assert property (wd_disable |=> !wd_reset)
        else $error("reset output while jumper set");
    // Pulse length is the bench's WD_PULSE of four cycles; the jumper may cut it short
    a_wd_pulse: assert property ($rose(wd_reset) && !wd_disable |-> wd_reset [*4] ##1 !wd_reset)
        else $error("reset pulse length wrong");
    a_periph_hit: assert property (chip_select && addr[15:4] != WINDOW
        |=> periph_sel == 8'h01 << $past(addr[15:13])
        && periph_rd == (periph_sel & {8{$past(read_not_write)}})
        && periph_wr == (periph_sel & {8{!$past(read_not_write)}}))
        else $error("peripheral decode wrong");
    a_periph_idle: assert property (!chip_select |=> periph_sel == 8'h00)
        else $error("peripheral selected without chip select");
    a_ser_route: assert property (1'b1 |=> ser_out == {$past(ser_in[ser_sel[7:6]]),
        $past(ser_in[ser_sel[5:4]]), $past(ser_in[ser_sel[3:2]]), $past(ser_in[ser_sel[1:0]])})
        else $error("serial route wrong");
    c_wd_fire: cover property ($rose(wd_reset));
    c_periph_wr: cover property (|periph_wr);
    c_out_write: cover property (wr_out);
endmodule : cpu_glue_asserts
bind cpu_glue cpu_glue_asserts #(.WINDOW(WINDOW)) chk (.*);

// ==== cpu_host.sv ====
// Processor bus model facing the glue block
`timescale 1ns/1ps
module cpu_host (
    input wire logic clk,
    output logic chip_select,
    output logic read_not_write,
    output logic [15:0] addr,
    output logic [7:0] wdata
);
    initial begin
        chip_select = 1'b0;
        read_not_write = 1'b1;
        addr = 16'h0000;
        wdata = 8'h00;
    end
    // One cycle: driven after an edge, taken at the next, then released
    task cyc(input logic [15:0] a, input logic rnw, input logic [7:0] d);
        @(posedge clk);
        chip_select <= 1'b1; addr <= a; read_not_write <= rnw; wdata <= d;
        @(posedge clk);
        chip_select <= 1'b0; addr <= ~a; wdata <= ~d; // Released address and data lines never hold their old value
        #1;
    endtask : cyc
endmodule : cpu_host

// ==== testbench.sv ====
// Self-checking bench for the processor glue block
`timescale 1ns/1ps
module testbench;
    import glue_pkg::*;
    logic clk = 0, reset = 1, wd_disable = 1, chip_select, read_not_write, rdata_oe, wd_reset;
    logic [15:0] addr, a;
    logic [7:0] wdata, rdata, out_pins, periph_sel, periph_rd, periph_wr, d, s, in_pins = 8'h00;
    logic [7:0] ser_sel = 8'h00;
    logic [3:0] ser_in = 4'h0, ser_out, si;
    int n_fail = 0, checked = 0, rises = 0, i, t;
    always #25 clk = ~clk;
    // Count reset pulses so quiet spans can be judged afterwards
    always @(posedge clk) if ($rose(wd_reset)) rises++;
    cpu_host host (.*);
    cpu_glue #(.WD_TIMEOUT(20), .WD_PULSE(4)) DUT (.*);
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task report_and_stop;
        if (n_fail == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    function logic [3:0] route(input logic [3:0] x, input logic [7:0] y);
        for (int k = 0; k < 4; k++) route[k] = x[y[2*k+:2]];
    endfunction : route
    function logic [7:0] dec(input logic [15:0] x);
        return 8'h01 << x[15:13];
    endfunction : dec
    initial begin
        #(50 * 2000);
        n_fail++;
        report_and_stop;
    end
    // Main sequence: ports, decode, routing, then the watchdog
    initial begin
        void'($urandom(89));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk); #1;
        chk("out_pins", OUT_PORT_RESET, out_pins);
        for (i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'hff : 8'($urandom);
            host.cyc({REG_WINDOW, OFS_OUT_PORT}, 1'b0, d);
            chk("out_pins", d, out_pins);
            host.cyc({REG_WINDOW, OFS_OUT_PORT}, 1'b1, 8'h00);
            chk("out_read", d, rdata);
            chk("out_kept", d, out_pins);
            @(posedge clk);
            s = 8'($urandom);
            in_pins <= s;
            host.cyc({REG_WINDOW, OFS_IN_PORT}, 1'b1, 8'h00);
            chk("in_read", s, rdata);
            host.cyc({REG_WINDOW, 4'(5 + i)}, 1'b1, 8'h00);
            chk("unmapped", READ_IDLE, rdata);
            a = {3'(i), 13'($urandom) & 13'h1fef};
            host.cyc(a, i[0], d);
            chk("periph_sel", dec(a), periph_sel);
            chk("periph_rd", i[0] ? dec(a) : 8'h00, periph_rd);
            chk("periph_wr", i[0] ? 8'h00 : dec(a), periph_wr);
            @(posedge clk);
            si = 4'($urandom);
            s = 8'($urandom);
            ser_in <= si;
            ser_sel <= s;
            @(posedge clk); #1;
            chk("ser_out", {4'h0, route(si, s)}, {4'h0, ser_out});
        end
        @(posedge clk);
        wd_disable <= 1'b0;
        t = 0;
        while (wd_reset !== 1'b1 && t < 40) begin
            @(posedge clk); #1;
            t++;
        end
        chk("wd_time", 8'h01, 8'(t >= 19 && t <= 21));
        repeat (8) @(posedge clk);
        t = rises;
        // Good key pairs every ten cycles hold the timeout off
        repeat (8) begin
            host.cyc({REG_WINDOW, OFS_WD_KEY_A}, 1'b0, WD_KEY_A_VALUE);
            host.cyc({REG_WINDOW, OFS_WD_KEY_B}, 1'b0, WD_KEY_B_VALUE);
            repeat (6) @(posedge clk);
        end
        chk("wd_quiet", t[7:0], rises[7:0]);
        repeat (3) begin
            host.cyc({REG_WINDOW, OFS_WD_KEY_A}, 1'b0, WD_KEY_A_VALUE);
            host.cyc({REG_WINDOW, OFS_WD_KEY_B}, 1'b0, 8'h5a);
            repeat (6) @(posedge clk);
        end
        chk("wd_fired", 8'h01, 8'(rises > t));
        // Set the jumper just after a pulse ends, so no pulse is cut short
        i = 0;
        while (wd_reset !== 1'b1 && i < 40) begin
            @(posedge clk); #1;
            i++;
        end
        while (wd_reset !== 1'b0 && i < 50) begin
            @(posedge clk); #1;
            i++;
        end
        @(posedge clk);
        wd_disable <= 1'b1;
        repeat (2) @(posedge clk);
        t = rises;
        repeat (50) @(posedge clk);
        chk("wd_jumper", t[7:0], rises[7:0]);
        host.cyc({REG_WINDOW, OFS_WD_STATUS}, 1'b1, 8'h00);
        chk("status", 8'(1 << ST_DISABLE_BIT), rdata);
        report_and_stop;
    end
endmodule : testbench
